// >>> src/fph_pkg.sv
// Package of the flash protection and pause block: opcodes, field positions,
// state and operation encodings.
// Assumes a single 100 MHz core clock that oversamples the serial pins.
package fph_pkg;

  localparam int unsigned SECTORS      = 64;
  localparam int unsigned SEC_W        = 6;
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned SEC_LSB      = 16;
  localparam int unsigned RANGE_W      = 3;

  // Instruction codes; the values are a plain choice for this block.
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_LOCK    = 8'he8;
  localparam logic [7:0] OPC_WRITE_LOCK   = 8'he5;
  localparam logic [7:0] OPC_PROGRAM      = 8'h02;
  localparam logic [7:0] OPC_SUB_ERASE    = 8'h20;
  localparam logic [7:0] OPC_SEC_ERASE    = 8'hd8;
  localparam logic [7:0] OPC_BULK_ERASE   = 8'hc7;

  // Byte counts at deselect that complete each non-read instruction, the byte count limit, and byte and bit positions.
  localparam logic [2:0] LEN_OPCODE_ONLY  = 3'h1;
  localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
  localparam logic [2:0] LEN_ADDR_CMD     = 3'h4;
  localparam logic [2:0] LEN_LOCK_WRITE   = 3'h5;
  localparam logic [2:0] LEN_PROGRAM_MIN  = 3'h5;
  localparam logic [2:0] BYTE_CNT_MAX     = 3'h7;
  localparam logic [2:0] BYTE_ADDR_HI     = 3'h1;
  localparam logic [2:0] BYTE_ADDR_LO     = 3'h3;
  localparam logic [2:0] BIT_LAST         = 3'h7;

  // Status byte layout.
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_WEL_BIT    = 1;
  localparam int unsigned ST_RANGE_LSB  = 2;
  localparam int unsigned ST_BOTTOM_BIT = 5;
  localparam int unsigned ST_STATUS_WRITE_DISABLE_BIT   = 7;

  // Lock byte layout.
  localparam int unsigned LK_WRITE_BIT = 0;
  localparam int unsigned LK_DOWN_BIT  = 1;

  localparam logic [RANGE_W-1:0] RANGE_NONE = 3'h0;
  localparam logic [RANGE_W-1:0] RANGE_ALL  = 3'h7;
  localparam logic [SEC_W:0]     SEC_TOTAL  = 7'h40;
  localparam logic [SEC_W:0]     SEC_ONE    = 7'h01;
  localparam logic [RANGE_W-1:0] RANGE_ONE  = 3'h1;

  typedef enum logic [1:0] {
    FPH_IDLE    = 2'b00,
    FPH_SHIFT   = 2'b01,
    FPH_PAUSE   = 2'b10,
    FPH_RELEASE = 2'b11
  } fph_state_t;

  typedef enum logic [1:0] {
    FPH_OP_PROGRAM   = 2'b00,
    FPH_OP_SUB_ERASE = 2'b01,
    FPH_OP_SEC_ERASE = 2'b10,
    FPH_OP_BULK      = 2'b11
  } fph_op_t;

endpackage

// >>> src/fph_protect.sv
// Serial flash protection and pause logic: per-sector lock registers, range
// protection, write-protect freeze and the pause condition of the serial port.
// Assumes the serial pins come from another domain and are oversampled by
// mclk; the memory array itself sits outside and reports its busy state.
`timescale 1ns/1ps

module fph_protect
  import fph_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          hold_n,
  input  wire logic                          wp_n,
  input  wire logic                          serial_in,
  output logic                               serial_out,
  output logic                               serial_out_oe,
  input  wire logic                          mem_busy,
  output logic                               op_go,
  output logic                               op_reject,
  output fph_pkg::fph_op_t                   op_kind,
  output logic [fph_pkg::ADDR_W-1:0]         op_addr,
  output logic                               write_enable_latch,
  output logic [fph_pkg::RANGE_W-1:0]        range_size,
  output logic                               range_bottom_select,
  output logic                               status_write_disable,
  output logic                               paused
);
  import fph_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage feeds only the second.
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic       sclk_d;
  logic       cs_d;
  logic       sclk_s;
  logic       cs_s;
  logic       hold_s;
  logic       wp_s;
  logic       sin_s;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // Idle pin levels: clock low, select, pause and protect high, so no false edge follows reset.
      pin_meta <= 5'h0e;
      pin_sync <= 5'h0e;
      sclk_d   <= 1'b0;
      cs_d     <= 1'b1;
    end
    else
    begin
      pin_meta <= {serial_in, wp_n, hold_n, cs_n, sclk};
      pin_sync <= pin_meta;
      sclk_d   <= pin_sync[0];
      cs_d     <= pin_sync[1];
    end
  end

  assign sclk_s = pin_sync[0];
  assign cs_s   = pin_sync[1];
  assign hold_s = pin_sync[2];
  assign wp_s   = pin_sync[3];
  assign sin_s  = pin_sync[4];

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cs_rise   = cs_s & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // Link state: selection and pause.
  fph_state_t state;
  fph_state_t next_state;

  // Sampling the levels only while the clock is low covers both the
  // coincident edge and the wait for the next low clock.
  wire pause_enter = ~cs_s & ~hold_s & ~sclk_s;
  wire pause_leave = hold_s & ~sclk_s;

  always_comb
  begin
    next_state = state;
    case (state)
      FPH_IDLE:
        if (!cs_s)
          next_state = FPH_SHIFT;
      FPH_SHIFT:
        if (cs_s)
          next_state = FPH_IDLE;
        else if (pause_enter)
          next_state = FPH_PAUSE;
      FPH_PAUSE:
        if (cs_s)
          next_state = FPH_RELEASE;
        else if (pause_leave)
          next_state = FPH_SHIFT;
      FPH_RELEASE:
        // Holding here stops a fresh select from dropping back into pause.
        if (hold_s)
          next_state = FPH_IDLE;
      default:
        next_state = FPH_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= FPH_IDLE;
    else
      state <= next_state;
  end

  assign paused = (state == FPH_PAUSE);

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift logic. Clock edges count only in the shifting state.
  logic [7:0] shift_in;
  logic [2:0] bit_idx;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [7:0] addr_hi;
  logic [7:0] addr_mid;
  logic [7:0] addr_lo;
  logic [7:0] data_byte;
  logic [7:0] out_shift;
  logic       out_active;

  wire        shifting  = (state == FPH_SHIFT);
  wire        take_bit  = shifting & ~cs_s & sclk_rise;
  wire        give_bit  = shifting & ~cs_s & sclk_fall;
  wire [7:0]  next_byte = {shift_in[6:0], sin_s};
  wire        byte_done = take_bit & (bit_idx == BIT_LAST);
  wire        frame_new = (state == FPH_IDLE) | (state == FPH_RELEASE);

  wire [SEC_W-1:0] lock_sec = addr_hi[SEC_W-1:0];
  logic [SECTORS-1:0] lock_wl;
  logic [SECTORS-1:0] lock_ld;
  logic [7:0] status_byte;
  logic [7:0] lock_byte;

  assign lock_byte = {6'h00, lock_ld[lock_sec], lock_wl[lock_sec]};

  always_ff @(posedge mclk)
  begin
    if (sys_rst | frame_new)
    begin
      shift_in   <= 8'h00;
      bit_idx    <= 3'h0;
      byte_cnt   <= 3'h0;
      opcode     <= 8'h00;
      addr_hi    <= 8'h00;
      addr_mid   <= 8'h00;
      addr_lo    <= 8'h00;
      data_byte  <= 8'h00;
      out_shift  <= 8'h00;
      out_active <= 1'b0;
    end
    else
    begin
      if (take_bit)
      begin
        shift_in <= next_byte;
        bit_idx  <= bit_idx + 3'h1;
      end
      if (byte_done)
      begin
        if (byte_cnt != BYTE_CNT_MAX)
          byte_cnt <= byte_cnt + 3'h1;
        case (byte_cnt)
          3'h0:    opcode   <= next_byte;
          3'h1:    addr_hi  <= next_byte;
          3'h2:    addr_mid <= next_byte;
          3'h3:    addr_lo  <= next_byte;
          default: data_byte <= next_byte;
        endcase
        if (byte_cnt == 3'h0 && next_byte == OPC_READ_STATUS)
        begin
          out_shift  <= status_byte;
          out_active <= 1'b1;
        end
        if (byte_cnt == BYTE_ADDR_LO && opcode == OPC_READ_LOCK)
        begin
          out_shift  <= lock_byte;
          out_active <= 1'b1;
        end
      end
      else if (give_bit & out_active)
        out_shift <= {out_shift[6:0], out_shift[7]};
    end
  end

  // Status write data sits in the first byte after the opcode.
  wire [7:0] status_data = addr_hi;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      serial_out <= 1'b0;
    else if (give_bit & out_active)
      serial_out <= out_shift[7];
  end

  assign serial_out_oe = shifting & ~cs_s & out_active;

  ////////////////////////////////////////////////////////////////////////////
  // Protection decode.
  function automatic logic range_hit(input logic [SEC_W-1:0] sec,
                                     input logic [RANGE_W-1:0] size,
                                     input logic               bottom);
    logic [SEC_W:0] span;
    span = SEC_ONE << (size - RANGE_ONE);
    if (size == RANGE_NONE)
      range_hit = 1'b0;
    else if (size == RANGE_ALL)
      range_hit = 1'b1;
    else if (bottom)
      range_hit = ({1'b0, sec} < span);
    else
      range_hit = ({1'b0, sec} >= (SEC_TOTAL - span));
  endfunction

  wire        sec_prot  = lock_wl[lock_sec] |
                          range_hit(lock_sec, range_size, range_bottom_select);
  wire        sr_frozen = status_write_disable & ~wp_s;

  assign status_byte = {status_write_disable, 1'b0, range_bottom_select, range_size,
                        write_enable_latch, mem_busy};

  ////////////////////////////////////////////////////////////////////////////
  // Instruction completion at deselect, on a whole number of bytes.
  wire cmd_end   = shifting & cs_rise & (bit_idx == 3'h0);
  wire is_write_enable_cmd   = (opcode == OPC_WRITE_ENABLE) & (byte_cnt == LEN_OPCODE_ONLY);
  wire is_wrsr   = (opcode == OPC_WRITE_STATUS) & (byte_cnt == LEN_STATUS_WRITE);
  wire is_write_lock_cmd   = (opcode == OPC_WRITE_LOCK) & (byte_cnt == LEN_LOCK_WRITE);
  wire is_prog   = (opcode == OPC_PROGRAM) & (byte_cnt >= LEN_PROGRAM_MIN);
  wire is_sse    = (opcode == OPC_SUB_ERASE) & (byte_cnt == LEN_ADDR_CMD);
  wire is_se     = (opcode == OPC_SEC_ERASE) & (byte_cnt == LEN_ADDR_CMD);
  wire is_be     = (opcode == OPC_BULK_ERASE) & (byte_cnt == LEN_OPCODE_ONLY);
  wire is_memop  = is_prog | is_sse | is_se | is_be;

  // A cycle already running keeps going; new modifying work is ignored while the array is busy.
  wire modify_ok = cmd_end & write_enable_latch & ~mem_busy;
  wire lock_wr   = modify_ok & is_write_lock_cmd & ~lock_ld[lock_sec];
  wire stat_wr   = modify_ok & is_wrsr & ~sr_frozen;
  wire be_ok     = (range_size == RANGE_NONE);
  wire mem_ok    = is_be ? be_ok : ~sec_prot;
  wire wel_clear = modify_ok & (is_write_lock_cmd | is_wrsr | is_memop);

  fph_op_t op_sel;
  assign op_sel = is_be  ? FPH_OP_BULK :
                  is_se  ? FPH_OP_SEC_ERASE :
                  is_sse ? FPH_OP_SUB_ERASE : FPH_OP_PROGRAM;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      lock_wl <= '0;
      lock_ld <= '0;
    end
    else if (lock_wr)
    begin
      lock_wl[lock_sec] <= data_byte[LK_WRITE_BIT];
      lock_ld[lock_sec] <= data_byte[LK_DOWN_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      range_size           <= RANGE_NONE;
      range_bottom_select  <= 1'b0;
      status_write_disable <= 1'b0;
    end
    else if (stat_wr)
    begin
      range_size           <= status_data[ST_RANGE_LSB +: RANGE_W];
      range_bottom_select  <= status_data[ST_BOTTOM_BIT];
      status_write_disable <= status_data[ST_STATUS_WRITE_DISABLE_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      write_enable_latch <= 1'b0;
    else if (wel_clear)
      write_enable_latch <= 1'b0;
    else if (cmd_end & is_write_enable_cmd)
      write_enable_latch <= 1'b1;
  end

  // Rejected operations finish like accepted ones, with a reject pulse in place of the go pulse.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      op_go     <= 1'b0;
      op_reject <= 1'b0;
      op_kind   <= FPH_OP_PROGRAM;
      op_addr   <= '0;
    end
    else
    begin
      op_go     <= modify_ok & is_memop & mem_ok;
      op_reject <= modify_ok & is_memop & ~mem_ok;
      if (modify_ok & is_memop)
      begin
        op_kind <= op_sel;
        op_addr <= {addr_hi, addr_mid, addr_lo};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  wire [SEC_W-1:0] op_sec = op_addr[SEC_LSB +: SEC_W];

  property p_lockdown_holds;
    @(posedge mclk) disable iff (sys_rst)
    ((lock_wl ^ $past(lock_wl)) & $past(lock_ld)) == '0;
  endproperty
  a_lockdown_holds: assert property (p_lockdown_holds)
    else $error("Locked-down sector changed its lock bits.");

  property p_lock_needs_wel;
    @(posedge mclk) disable iff (sys_rst)
    (lock_wl != $past(lock_wl)) |-> $past(write_enable_latch) && !write_enable_latch;
  endproperty
  a_lock_needs_wel: assert property (p_lock_needs_wel)
    else $error("Lock bits changed without the write-enable latch.");

  property p_go_unprotected;
    @(posedge mclk) disable iff (sys_rst)
    op_go && op_kind != FPH_OP_BULK |->
      !lock_wl[op_sec] && !range_hit(op_sec, range_size, range_bottom_select);
  endproperty
  a_go_unprotected: assert property (p_go_unprotected)
    else $error("Operation granted on a protected sector.");

  property p_bulk_range;
    @(posedge mclk) disable iff (sys_rst)
    op_go && op_kind == FPH_OP_BULK |-> range_size == RANGE_NONE;
  endproperty
  a_bulk_range: assert property (p_bulk_range)
    else $error("Bulk erase granted with range protection set.");

  property p_frozen_status;
    @(posedge mclk) disable iff (sys_rst)
    $past(sr_frozen) |-> $stable(range_size) && $stable(status_write_disable);
  endproperty
  a_frozen_status: assert property (p_frozen_status)
    else $error("Status bits changed while frozen.");

  property p_pause_float;
    @(posedge mclk) disable iff (sys_rst)
    paused |-> !serial_out_oe ##1 ($stable(bit_idx) && $stable(byte_cnt) && $stable(shift_in));
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("Output driven during pause.");

  property p_pause_enter;
    @(posedge mclk) disable iff (sys_rst)
    state == FPH_SHIFT && !cs_s && !hold_s && !sclk_s |=> paused;
  endproperty
  a_pause_enter: assert property (p_pause_enter)
    else $error("Pause not entered with clock low.");

  property p_pause_deselect;
    @(posedge mclk) disable iff (sys_rst)
    paused && cs_s |=> state == FPH_RELEASE ##1 (bit_idx == 3'h0 && byte_cnt == 3'h0);
  endproperty
  a_pause_deselect: assert property (p_pause_deselect)
    else $error("Deselect during pause did not reset the serial logic.");

  c_pause: cover property (@(posedge mclk) disable iff (sys_rst) $rose(paused));
  c_lock_write: cover property (@(posedge mclk) disable iff (sys_rst) lock_wr);
  c_op_go: cover property (@(posedge mclk) disable iff (sys_rst) op_go);
  c_op_reject: cover property (@(posedge mclk) disable iff (sys_rst) op_reject);

endmodule

// >>> verification/fph_spi_master.sv
// Bus master model that drives the serial pins of the protection block.
// Assumes mode 0 and a 125 ns serial clock that is unrelated to mclk.
`timescale 1ns/1ps

module fph_spi_master (
  output logic     sclk,
  output logic     cs_n,
  output logic     hold_n,
  output logic     serial_in,
  input  wire logic serial_out
);
  localparam realtime HALF = 62.5;

  initial
  begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    hold_n    = 1'b1;
    serial_in = 1'b0;
  end

  // Data changes while the clock is low and is taken at the rise.
  task automatic rise(input logic b);
    serial_in = b;
    #HALF sclk = 1'b1;
  endtask

  task automatic fall();
    #HALF sclk = 1'b0;
  endtask

  // Read data is taken at the rise, half a period after the fall at which the device changes it.
  task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = n - 1; i >= 0; i--)
    begin
      rise(tx[i]);
      rx[i] = serial_out;
      fall();
    end
  endtask

  task automatic sel();
    #HALF cs_n = 1'b0;
  endtask

  // A released data line is flipped so that a stale bit never reads as data.
  task automatic desel();
    #HALF cs_n = 1'b1;
    serial_in = ~serial_in;
    #HALF;
  endtask

  // The pause pin changes half a period later, selected or not; the bench releases it before the next select.
  task automatic pause(input logic on);
    #HALF hold_n = ~on;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench of the flash protection and pause block.
// Assumes the serial master model drives the pins; mem_busy and wp_n come from here.
`timescale 1ns/1ps

module testbench;
  import fph_pkg::*;

  logic               mclk;
  logic               sys_rst;
  logic               wp_n;
  wire                mem_busy;
  logic               busy_force;
  logic [3:0]         busy_cnt;
  wire                sclk;
  wire                cs_n;
  wire                hold_n;
  wire                serial_in;
  logic               serial_out;
  wire                so_line;
  logic               serial_out_oe;
  logic               op_go;
  logic               op_reject;
  fph_op_t            op_kind;
  logic [ADDR_W-1:0]  op_addr;
  logic               write_enable_latch;
  logic [RANGE_W-1:0] range_size;
  logic               range_bottom_select;
  logic               status_write_disable;
  logic               paused;
  logic [7:0]         rx;
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 go_cnt = 0;
  int                 rej_cnt = 0;

  fph_protect uut (
    .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
    .wp_n(wp_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .mem_busy(mem_busy), .op_go(op_go),
    .op_reject(op_reject), .op_kind(op_kind), .op_addr(op_addr),
    .write_enable_latch(write_enable_latch), .range_size(range_size),
    .range_bottom_select(range_bottom_select),
    .status_write_disable(status_write_disable), .paused(paused)
  );

  fph_spi_master m (
    .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .serial_in(serial_in),
    .serial_out(so_line)
  );

  // A released output line shows the inverse, so a stale bit never passes as read data.
  assign so_line = serial_out_oe ? serial_out : ~serial_out;

  // The array stays busy for a while after each granted operation.
  assign mem_busy = busy_force | (busy_cnt != 4'h0);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (op_go === 1'b1)
      go_cnt++;
    if (op_reject === 1'b1)
      rej_cnt++;
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
      busy_cnt <= 4'h0;
    else if (op_go === 1'b1)
      busy_cnt <= 4'hf;
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk) #1 sys_rst = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
    cyc(2);
  endtask

  // One framed instruction; rx keeps the last byte that came back.
  task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] pl);
    m.sel();
    m.bits(8, op, rx);
    for (int k = nb - 1; k >= 0; k--)
      m.bits(8, pl[8*k +: 8], rx);
    m.desel();
    cyc(6);
  endtask

  task automatic wrsr(input logic [7:0] v);
    cmd(OPC_WRITE_ENABLE, 0, 0);
    cmd(OPC_WRITE_STATUS, 1, {24'h0, v});
  endtask

  task automatic wl(input logic [5:0] s, input logic [7:0] v);
    cmd(OPC_WRITE_ENABLE, 0, 0);
    cmd(OPC_WRITE_LOCK, 4, {2'b00, s, 16'h0, v});
  endtask

  task automatic rdl(input logic [5:0] s, input logic [7:0] exp);
    cmd(OPC_READ_LOCK, 4, {2'b00, s, 24'h0});
    check("lock byte", exp, rx);
  endtask

  // Enable, then a modifying instruction aimed at one sector; count the pulses.
  task automatic mod_op(input logic [7:0] op, input logic [5:0] s, input logic eg,
                        input logic er);
    int g;
    int j;
    int nb;
    g = go_cnt;
    j = rej_cnt;
    nb = (op == OPC_BULK_ERASE) ? 0 : (op == OPC_PROGRAM) ? 4 : 3;
    cmd(OPC_WRITE_ENABLE, 0, 0);
    cmd(op, nb, {2'b00, s, 24'h0} >> (8 * (4 - nb)));
    check("op_go count", eg, go_cnt - g);
    check("op_reject count", er, rej_cnt - j);
    // An instruction ignored while busy keeps the latch set.
    check("write_enable_latch", busy_force, write_enable_latch);
  endtask

  function automatic logic prot(input int s, input int n, input int b);
    int c;
    if (n == 0)
      return 1'b0;
    if (n == 7)
      return 1'b1;
    c = 1 << (n - 1);
    return b ? (s < c) : (s >= 64 - c);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int c;
    int lo;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    busy_force = 1'b0;
    do_reset();
    check("range_size", 0, range_size);
    check("paused", 0, paused);
    check("serial_out_oe", 0, serial_out_oe);
    // Both boundary sectors of every range setting, plus bulk erase.
    for (int b = 0; b < 2; b++)
      for (int n = 0; n < 8; n++)
      begin
        c = (n == 0 || n == 7) ? 32 : 1 << (n - 1);
        lo = b ? c - 1 : 63 - c;
        wrsr({3'b000, b[0], n[2:0], 2'b00});
        check("range_size", n, range_size);
        check("range_bottom_select", b, range_bottom_select);
        mod_op(OPC_PROGRAM, lo, !prot(lo, n, b), prot(lo, n, b));
        mod_op(OPC_SEC_ERASE, lo + 1, !prot(lo + 1, n, b), prot(lo + 1, n, b));
        mod_op(OPC_BULK_ERASE, 0, n == 0, n != 0);
      end
    // Per-sector locks combined with a one-sector top range.
    wrsr(8'h04);
    wl(6'd5, 8'h01);
    check("write_enable_latch", 0, write_enable_latch);
    rdl(6'd5, 8'h01);
    mod_op(OPC_SEC_ERASE, 6'd5, 0, 1);
    mod_op(OPC_SUB_ERASE, 6'd4, 1, 0);
    check("op_kind", FPH_OP_SUB_ERASE, op_kind);
    check("op_addr", 24'h040000, op_addr);
    mod_op(OPC_SEC_ERASE, 6'd63, 0, 1);
    cmd(OPC_WRITE_LOCK, 4, {2'b00, 6'd5, 24'h0});
    rdl(6'd5, 8'h01);
    wl(6'd5, 8'h00);
    rdl(6'd5, 8'h00);
    mod_op(OPC_PROGRAM, 6'd5, 1, 0);
    wl(6'd9, 8'h03);
    wl(6'd9, 8'h00);
    rdl(6'd9, 8'h03);
    mod_op(OPC_SEC_ERASE, 6'd9, 0, 1);
    busy_force = 1'b1;
    mod_op(OPC_SEC_ERASE, 6'd10, 0, 0);
    busy_force = 1'b0;
    do_reset();
    rdl(6'd9, 8'h00);
    // Write-protect pin freeze.
    wrsr(8'h88);
    @(posedge mclk) #1 wp_n = 1'b0;
    wrsr(8'h00);
    check("range_size", 2, range_size);
    check("status_write_disable", 1, status_write_disable);
    cmd(OPC_READ_STATUS, 1, 0);
    check("status byte", 8'h88, rx);
    @(posedge mclk) #1 wp_n = 1'b1;
    wrsr(8'h00);
    check("status_write_disable", 0, status_write_disable);
    @(posedge mclk) #1 wp_n = 1'b0;
    wrsr(8'h0c);
    check("range_size", 3, range_size);
    @(posedge mclk) #1 wp_n = 1'b1;
    // Pause inside a status write, asserted while the clock is high and entered at the fall.
    m.pause(1'b1);
    cyc(6);
    check("paused", 0, paused);
    m.pause(1'b0);
    cmd(OPC_WRITE_ENABLE, 0, 0);
    m.sel();
    m.bits(8, OPC_WRITE_STATUS, rx);
    m.bits(3, 8'h00, rx);
    m.rise(1'b1);
    m.pause(1'b1);
    cyc(3);
    check("paused", 0, paused);
    m.fall();
    cyc(6);
    check("paused", 1, paused);
    check("serial_out_oe", 0, serial_out_oe);
    m.bits(3, 8'h07, rx);
    m.pause(1'b0);
    cyc(6);
    check("paused", 0, paused);
    m.bits(4, 8'h04, rx);
    m.desel();
    cyc(6);
    check("range_size", 5, range_size);
    // Deselect in mid-pause drops the frame.
    cmd(OPC_WRITE_ENABLE, 0, 0);
    m.sel();
    m.bits(8, OPC_WRITE_STATUS, rx);
    m.bits(4, 8'h00, rx);
    m.pause(1'b1);
    cyc(6);
    m.desel();
    cyc(6);
    check("range_size", 5, range_size);
    check("write_enable_latch", 1, write_enable_latch);
    m.pause(1'b0);
    wrsr(8'h00);
    check("range_size", 0, range_size);
    stop_test();
  end

  initial
  begin
    // The tests need about 400 us; this leaves margin and stays well under 100k cycles.
    #600_000;
    err_total++;
    stop_test();
  end
endmodule
